/* verilog/l2a_pkg.sv */
package l2a_pkg;

  // Word address of second-level RAM (64 Kbytes of 32-bit words)
  localparam int ADDR_W = 14;

  // Four banks, 64 bits wide: two words per bank row
  localparam int BANK_N = 4;
  localparam int BANK_W = 2;
  localparam int BANK_LSB = 1;

  // Aligned blocks of 32 words
  localparam int BLOCK_WORDS = 32;
  localparam int BLOCK_LSB = 5;

  // Store ports of the data cache
  localparam int STORE_PORTS = 2;

  // Worst-case block write by the data cache, in cycles
  localparam int STALL_CYCLES = 256;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] STALL_LIMIT = 9'h100;
  localparam logic [CNT_W-1:0] CNT_RESET = 9'h000;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } l2a_req_s;

  typedef struct packed {
    logic [CNT_W-1:0] stall_cnt;
  } l2a_state_s;

endpackage

/* verilog/l2a_port_cmp.sv */
`timescale 1ns/1ps
module l2a_port_cmp
  import l2a_pkg::*;
(
  // Clock and reset, used by checks only
  input wire logic clock,
  input wire logic rst_n,
  // Addresses compared
  input wire logic [ADDR_W-1:0] a_addr,
  input wire logic [ADDR_W-1:0] b_addr,
  // Results
  output logic same_bank,
  output logic same_block
);

  // Bank from the 64-bit group index
  assign same_bank = a_addr[BANK_LSB +: BANK_W] == b_addr[BANK_LSB +: BANK_W];
  // Block from the 32-word aligned index
  assign same_block = a_addr[ADDR_W-1:BLOCK_LSB] == b_addr[ADDR_W-1:BLOCK_LSB];

  a_bank_map: assert property (@(posedge clock) disable iff (!rst_n)
    same_bank == ((a_addr[2:1] ^ b_addr[2:1]) == 2'h0))
    else $error("bank match not taken from address bits 2 to 1");

  a_block_map: assert property (@(posedge clock) disable iff (!rst_n)
    same_block |-> ((a_addr >> 5) == (b_addr >> 5)) && (same_bank || a_addr[2:1] != b_addr[2:1]))
    else $error("block match not on a 32-word boundary");

endmodule

/* verilog/l2a_arbiter.sv */
`timescale 1ns/1ps
// Function
// - With the priority bit set, crossbar requests win bank conflicts against data-cache stores in other 32-word blocks.
// - With the priority bit clear, data-cache stores win every bank conflict, without bound.
// - Same-block checks use 32-word blocks aligned on 32-word boundaries.
// - A conflict inside one 32-word block goes to the data cache, with the priority bit set only until the stall limit.
// - With the priority bit set, the same-block stall of the crossbar ends after at most 256 cycles.
// - RAM is four 64-bit banks, successive 64-bit groups in successive banks.
// - A conflict is two requests to one bank in one cycle; different banks proceed together.
// - Up to two stores per cycle, each arbitrated as a separate access.
module l2a_arbiter
  import l2a_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Priority bit of cache_config_register
  input wire logic xbar_priority,
  // Transfer crossbar port
  input wire l2a_req_s xbar_req,
  output logic xbar_gnt,
  // Data cache store ports
  input wire l2a_req_s [STORE_PORTS-1:0] dcache_req,
  output logic [STORE_PORTS-1:0] dcache_gnt,
  // Status
  output logic [CNT_W-1:0] xbar_stall_cycles,
  output logic same_block_hold
);

  l2a_state_s st_r;
  l2a_state_s st_nxt;
  logic [STORE_PORTS-1:0] bank_hit;
  logic [STORE_PORTS-1:0] block_hit;
  logic [STORE_PORTS-1:0] conflict;
  logic [STORE_PORTS-1:0] xb_wins;
  logic [STORE_PORTS-1:0] live;
  logic pair_bank;
  logic expired;
  logic hold;

  // Per-store compare against the crossbar address
  l2a_port_cmp u_cmp0 (
    .clock(clock),
    .rst_n(rst_n),
    .a_addr(dcache_req[0].addr),
    .b_addr(xbar_req.addr),
    .same_bank(bank_hit[0]),
    .same_block(block_hit[0])
  );

  l2a_port_cmp u_cmp1 (
    .clock(clock),
    .rst_n(rst_n),
    .a_addr(dcache_req[1].addr),
    .b_addr(xbar_req.addr),
    .same_bank(bank_hit[1]),
    .same_block(block_hit[1])
  );

  // Two stores to one bank go one after the other
  assign pair_bank = dcache_req[0].addr[BANK_LSB +: BANK_W]
                     == dcache_req[1].addr[BANK_LSB +: BANK_W];

  always_comb begin
    st_nxt = st_r;
    expired = st_r.stall_cnt >= STALL_LIMIT;
    // Store queued behind the other in its bank does not compete
    live[0] = dcache_req[0].valid;
    live[1] = dcache_req[1].valid & ~(dcache_req[0].valid & pair_bank);
    for (int i = 0; i < STORE_PORTS; i++) begin
      conflict[i] = live[i] & xbar_req.valid & bank_hit[i];
      xb_wins[i] = xbar_priority & (~block_hit[i] | expired);
      dcache_gnt[i] = live[i] & ~(conflict[i] & xb_wins[i]);
    end
    hold = xbar_req.valid & xbar_priority & ~expired & |(conflict & block_hit);
    xbar_gnt = xbar_req.valid & ~|(conflict & ~xb_wins);
    // Count same-block stall cycles; cleared once the crossbar moves
    if (hold) begin
      st_nxt.stall_cnt = st_r.stall_cnt + 9'h001;
    end else begin
      st_nxt.stall_cnt = CNT_RESET;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{stall_cnt: CNT_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign xbar_stall_cycles = st_r.stall_cnt;
  assign same_block_hold = st_r.stall_cnt != CNT_RESET;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // Priority and bank conflicts
  a_prio_xbar_wins: assert property (
    xbar_priority && xbar_req.valid && conflict[0] && !block_hit[0]
    && !(conflict[1] && block_hit[1]) |-> xbar_gnt && !dcache_gnt[0])
    else $error("crossbar lost a conflict with priority set");

  a_noprio_dc_wins: assert property (
    !xbar_priority && conflict[0] |-> dcache_gnt[0] && !xbar_gnt)
    else $error("crossbar won a conflict with priority clear");

  a_block_dc_wins: assert property (
    conflict[0] && block_hit[0] && xbar_stall_cycles < STALL_LIMIT
    |-> dcache_gnt[0] && !xbar_gnt)
    else $error("same-block store did not win");

  a_stall_range: assert property (
    xbar_stall_cycles <= STALL_LIMIT)
    else $error("stall counter passed 256");

  a_stall_bound: assert property (
    xbar_priority && xbar_req.valid && xbar_stall_cycles == STALL_LIMIT |-> xbar_gnt)
    else $error("same-block stall exceeded 256 cycles");

  a_stall_counts: assert property (
    xbar_priority && xbar_req.valid && !xbar_gnt && |(conflict & block_hit)
    |=> xbar_stall_cycles == $past(xbar_stall_cycles) + 9'h001)
    else $error("stall counter did not advance");

  a_free_bank_go: assert property (
    xbar_req.valid && !conflict[0] && !conflict[1] |-> xbar_gnt)
    else $error("unopposed crossbar request delayed");

  a_diff_bank_both: assert property (
    xbar_req.valid && dcache_req[0].valid && !bank_hit[0] && !dcache_req[1].valid
    |-> xbar_gnt && dcache_gnt[0])
    else $error("different banks did not proceed together");

  a_dual_store: assert property (
    dcache_req[0].valid && dcache_req[1].valid && !xbar_req.valid
    |-> dcache_gnt[0] && (dcache_gnt[1] != pair_bank))
    else $error("dual stores not arbitrated separately");

  // Second store port
  a_noprio_port1: assert property (
    !xbar_priority && conflict[1] |-> dcache_gnt[1] && !xbar_gnt)
    else $error("crossbar beat store port 1 with priority clear");

  a_prio_port1_wins: assert property (
    xbar_priority && conflict[1] && !block_hit[1] && !conflict[0]
    |-> xbar_gnt && !dcache_gnt[1])
    else $error("crossbar lost to store port 1 with priority set");

  a_block_port1: assert property (
    conflict[1] && block_hit[1] && xbar_stall_cycles < STALL_LIMIT
    |-> dcache_gnt[1] && !xbar_gnt)
    else $error("same-block store on port 1 did not win");

  a_expire_port1: assert property (
    xbar_priority && conflict[1] && xbar_stall_cycles == STALL_LIMIT |-> !dcache_gnt[1])
    else $error("store port 1 kept the bank after the stall limit");

  a_diff_bank_port1: assert property (
    xbar_req.valid && dcache_req[1].valid && !bank_hit[1] && !dcache_req[0].valid
    |-> xbar_gnt && dcache_gnt[1])
    else $error("port 1 and crossbar in different banks did not proceed together");

  // Same-block stall counter
  a_stall_start: assert property (
    xbar_priority && conflict[0] && block_hit[0] && xbar_stall_cycles == CNT_RESET
    |=> xbar_stall_cycles == 9'h001)
    else $error("stall counter did not start at one");

  a_stall_clears: assert property (
    xbar_gnt |=> xbar_stall_cycles == CNT_RESET)
    else $error("stall counter kept after a crossbar grant");

  a_hold_follows: assert property (
    hold |=> same_block_hold)
    else $error("same-block hold flag not raised during a stall");

  a_expire_store_waits: assert property (
    xbar_priority && conflict[0] && xbar_stall_cycles == STALL_LIMIT |-> !dcache_gnt[0])
    else $error("store kept the bank after the stall limit");

  a_noprio_no_count: assert property (
    !xbar_priority |=> xbar_stall_cycles == CNT_RESET)
    else $error("stall counter ran with priority clear");

  a_stall_cause: assert property (
    xbar_stall_cycles != CNT_RESET |-> $past(xbar_priority) && $past(xbar_req.valid))
    else $error("stall counted without a prioritised crossbar request");

  // Grants and bank sharing
  a_xbar_gnt_req: assert property (
    xbar_gnt |-> xbar_req.valid)
    else $error("crossbar granted without a request");

  a_dc_gnt_req: assert property (
    (dcache_gnt & ~{dcache_req[1].valid, dcache_req[0].valid}) == 2'h0)
    else $error("store granted without a request");

  a_free_store_go: assert property (
    dcache_req[0].valid && !conflict[0] |-> dcache_gnt[0])
    else $error("unopposed store delayed");

  a_free_store1_go: assert property (
    dcache_req[1].valid && !dcache_req[0].valid && !conflict[1] |-> dcache_gnt[1])
    else $error("unopposed store on port 1 delayed");

  a_single_owner: assert property (
    xbar_gnt |-> !(dcache_gnt[0] && bank_hit[0]) && !(dcache_gnt[1] && bank_hit[1]))
    else $error("crossbar and a store granted the same bank");

  a_pair_one_bank: assert property (
    dcache_gnt == 2'h3 |-> !pair_bank)
    else $error("two stores granted the same bank");

  c_prio_conflict: cover property (xbar_priority && conflict[0] && xbar_gnt);
  c_block_hold: cover property (same_block_hold ##1 xbar_gnt);
  c_stall_expire: cover property (xbar_stall_cycles == STALL_LIMIT && xbar_gnt);
  c_dual_store: cover property (dcache_gnt == 2'h3 && xbar_gnt);
  c_noprio_starve: cover property (!xbar_priority && conflict[0] && !xbar_gnt);

endmodule

/* verif/l2a_xbar_model.sv */
`timescale 1ns/1ps
module l2a_xbar_model
  import l2a_pkg::*;
(
  // Control
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [ADDR_W-1:0] start_addr,
  // Crossbar port
  input wire logic gnt,
  output l2a_req_s req
);
  // Hold until granted, then drop the request and invert the address
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req <= '0;
    end else if (start) begin
      req <= {1'b1, start_addr};
    end else if (req.valid && gnt) begin
      req <= {1'b0, ~req.addr};
    end
  end
endmodule

/* verif/l2a_arbiter_tb_top.sv */
`timescale 1ns/1ps
module l2a_arbiter_tb_top
  import l2a_pkg::*;
;
  typedef struct packed {
    logic p;
    logic [ADDR_W-1:0] xa;
    l2a_req_s d1;
    l2a_req_s d0;
    logic [2:0] g;
  } l2a_row_s;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic xprio = 1'b0;
  logic start = 1'b0;
  logic [ADDR_W-1:0] saddr = '0;
  l2a_req_s xreq;
  l2a_req_s [STORE_PORTS-1:0] dreq = '0;
  logic xbar_gnt;
  logic [1:0] dcache_gnt;
  logic [CNT_W-1:0] xbar_stall_cycles;
  logic same_block_hold;
  int fails = 0;
  int total_checks = 0;
  int n;
  l2a_row_s rows [8] = '{
    '{1'b0, 14'h0009, 15'h0000, 15'h4000, 3'b001},
    '{1'b0, 14'h0029, 15'h0000, 15'h4000, 3'b001},
    '{1'b1, 14'h0029, 15'h0000, 15'h4000, 3'b100},
    '{1'b1, 14'h0009, 15'h0000, 15'h4000, 3'b001},
    '{1'b1, 14'h0020, 15'h0000, 15'h4018, 3'b100},
    '{1'b0, 14'h0002, 15'h4004, 15'h4000, 3'b111},
    '{1'b0, 14'h0002, 15'h4001, 15'h4000, 3'b101},
    '{1'b0, 14'h0006, 15'h0000, 15'h4000, 3'b101}};
  initial begin
    forever #2.5 clock = ~clock;
  end
  l2a_arbiter l2a_arbiter_inst (.clock(clock), .rst_n(rst_n), .xbar_priority(xprio),
    .xbar_req(xreq), .xbar_gnt(xbar_gnt), .dcache_req(dreq), .dcache_gnt(dcache_gnt),
    .xbar_stall_cycles(xbar_stall_cycles), .same_block_hold(same_block_hold));
  l2a_xbar_model l2a_xbar_model_inst (.clock(clock), .rst_n(rst_n), .start(start),
    .start_addr(saddr), .gnt(xbar_gnt), .req(xreq));
  task automatic final_report();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk_g(input logic [2:0] v, input logic [2:0] e);
    total_checks++;
    if (v !== e) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, v, e);
    end
  endtask
  task automatic chk_c(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] e);
    total_checks++;
    if (v !== e) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, v, e);
    end
  endtask
  // Request from both store ports, and from the crossbar one cycle later
  task automatic issue(input logic p, input logic [ADDR_W-1:0] a, input logic [29:0] d);
    @(posedge clock);
    xprio <= p;
    start <= 1'b1;
    saddr <= a;
    dreq <= d;
    @(posedge clock);
    start <= 1'b0;
    #1;
  endtask
  initial begin
    #15000;
    fails++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk_c(xbar_stall_cycles, CNT_RESET);
    foreach (rows[i]) begin
      issue(rows[i].p, rows[i].xa, {rows[i].d1, rows[i].d0});
      chk_g({xbar_gnt, dcache_gnt}, rows[i].g);
      @(posedge clock);
      dreq <= '0;
      repeat (2) @(posedge clock);
    end
    // Stores held in the crossbar's block
    issue(1'b1, 14'h0009, 30'h0000_4000);
    n = 0;
    while (xbar_gnt !== 1'b1 && n < 300) begin
      n++;
      @(posedge clock);
      #1;
    end
    chk_c(CNT_W'(n), STALL_LIMIT);
    chk_c(xbar_stall_cycles, STALL_LIMIT);
    chk_g({same_block_hold, dcache_gnt}, 3'b100);
    @(posedge clock);
    dreq <= '0;
    #1;
    chk_c(xbar_stall_cycles, CNT_RESET);
    // Same-block stores with priority clear keep the crossbar out without bound
    issue(1'b0, 14'h0009, 30'h0000_4000);
    repeat (300) @(posedge clock);
    #1;
    chk_g({xbar_gnt, dcache_gnt}, 3'b001);
    chk_c(xbar_stall_cycles, CNT_RESET);
    // Priority set mid-stall starts the counter
    @(posedge clock);
    xprio <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk_c(xbar_stall_cycles, 9'h003);
    // Reset in mid-stall clears the counter and the crossbar request
    @(posedge clock);
    rst_n <= 1'b0;
    #1;
    chk_g({same_block_hold, dcache_gnt}, 3'b001);
    chk_c(xbar_stall_cycles, CNT_RESET);
    @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    chk_g({xbar_gnt, dcache_gnt}, 3'b001);
    chk_c(xbar_stall_cycles, CNT_RESET);
    issue(1'b1, 14'h0009, 30'h0000_4000);
    @(posedge clock);
    #1;
    chk_c(xbar_stall_cycles, 9'h001);
    final_report();
  end
endmodule
